/* File: src/fdcrf_pkg.sv */
// Constants, types and reset state for the floppy controller rate, data port and status block.
// Assumes one 50 MHz clock and a command sequencer on the same clock that reports the phase.
//
// Behaviour
// RL1: Precompensation code 111 zero, 001-110 rising steps.
// RL2: Default code gives 41.7 ns at 1 Mb/s.
// RL3: Rate bits survive soft reset; hard reset 250k.
// RL4: Rate code 11 is 1 Mb/s, illegal FM.
// RL5: Host polls request and direction before each byte.
// RL6: FIFO used only for execution phase data.
// RL7: Locked FIFO enable survives soft reset only.
// RL8: Burst mode holds request until transfer done.
// RL9: Non-burst mode drops request 350 ns between bytes.
// RL10: FIFO disable separately for read and write.
// RL11: Hard reset disables FIFO, threshold zero.
// RL12: Host answers within threshold-scaled service time.
// RL13: Legacy mode drives only bit 7, media change.
// RL14: Soft reset leaves input status untouched.
// RL15: Second mode: ones, rate, density flag.
// RL16: Third mode: inverted media, engine, skip, rate.
// RL17: Media change undefined during power-down.
// RL18: Rate control write-only; latest rate write wins.
// RL19: Direction flag 0 host writes, 1 host reads.
// RL20: Static mode input picks status layout.
package fdcrf_pkg;

  // Register offsets on the 3-bit register port.
  localparam logic [2:0] ADDR_RATE_SEL   = 3'h0;
  localparam logic [2:0] ADDR_RATE_CTL   = 3'h1;
  localparam logic [2:0] ADDR_IN_STATUS  = 3'h2;
  localparam logic [2:0] ADDR_DATA_PORT  = 3'h3;
  localparam logic [2:0] ADDR_MAIN_STATE = 3'h4;
  localparam logic [2:0] ADDR_FIFO_CFG   = 3'h5;
  localparam logic [2:0] ADDR_FIFO_LEVEL = 3'h6;
  localparam logic [2:0] ADDR_OUT_CTL    = 3'h7;

  // Field positions.
  localparam int RS_SW_RESET    = 7;
  localparam int RS_LOW_POWER   = 6;
  localparam int RS_PRECOMP_LSB = 2;
  localparam int RC_SKIP_SHIFT  = 2;
  localparam int CFG_FIFO_ON    = 0;
  localparam int CFG_PERSIST    = 1;
  localparam int CFG_BURST      = 2;
  localparam int CFG_NO_RD      = 3;
  localparam int CFG_NO_WR      = 4;
  localparam int CFG_FM         = 5;
  localparam int OC_RUN         = 2;
  localparam int OC_ENGINE_ON   = 3;

  // Rate select encodings and hardware reset rate.
  localparam logic [1:0] RATE_500 = 2'h0;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam logic [1:0] RATE_250 = 2'h2;
  localparam logic [1:0] RATE_1M  = 2'h3;
  localparam logic [1:0] RST_RATE = RATE_250;

  // Precompensation codes; shift is counted in steps of 41.7 ns.
  localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
  localparam logic [2:0] PRECOMP_NONE    = 3'h7;
  localparam logic [2:0] SHIFT_ZERO      = 3'h0;
  localparam logic [2:0] SHIFT_DEF_1M    = 3'h1;
  localparam logic [2:0] SHIFT_DEF_LOW   = 3'h3;

  // Input status layouts chosen by the mode pins.
  localparam logic [1:0] MODE_AT     = 2'h0;
  localparam logic [1:0] MODE_SECOND = 2'h1;
  localparam logic [1:0] MODE_THIRD  = 2'h2;
  localparam logic [3:0] DIR_ONES    = 4'hf;

  // FIFO geometry.
  localparam int         FIFO_DEPTH  = 16;
  localparam logic [4:0] CAP_FULL    = 5'h10;
  localparam logic [4:0] CAP_BYPASS  = 5'h01;

  // Request gap between non-burst transfers.
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         GAP_NS        = 350;
  localparam int         GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] GAP_CNT       = 5'(GAP_CYC);

  typedef enum logic [2:0] {
    PH_CMD    = 3'b001,
    PH_EXEC   = 3'b010,
    PH_RESULT = 3'b100
  } fdcrf_phase_t;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [3:0]                 wptr;
    logic [3:0]                 rptr;
    logic [4:0]                 cnt;
    logic [1:0]                 rate;
    logic [2:0]                 precomp;
    logic                       skip_shift;
    logic                       low_power;
    logic                       engine_on;
    logic                       run;
    logic                       fifo_on;
    logic                       persist;
    logic                       burst;
    logic                       no_rd;
    logic                       no_wr;
    logic                       fm;
    logic [3:0]                 level;
    logic                       req;
    logic [4:0]                 gap;
    fdcrf_phase_t               prev_phase;
    logic                       media_s1;
    logic                       media_s2;
    logic [1:0]                 mode_s1;
    logic [1:0]                 mode_s2;
    logic [7:0]                 rd_data;
    logic [7:0]                 rd_data_en;
    logic                       in_ready;
    logic                       out_valid;
    logic [7:0]                 out_data;
    logic                       dma_req;
    logic                       irq_req;
    logic [2:0]                 shift;
    logic                       illegal;
  } fdcrf_state_t;

  localparam fdcrf_state_t STATE_RESET = '{
    default:    '0,
    rate:       RST_RATE,
    run:        1'b1,
    shift:      SHIFT_DEF_LOW,
    prev_phase: PH_CMD
  };

endpackage : fdcrf_pkg

/* File: src/fdcrf_regs.sv */
// Rate, precompensation, data port with 16-byte FIFO, and input status register.
// Assumes a register master on mclk and a command sequencer on mclk that supplies the phase.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fdcrf_regs
  import fdcrf_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Register port
  input  wire logic [2:0]   addr,
  input  wire logic [7:0]   wr_data,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  output logic      [7:0]   rd_data,
  output logic      [7:0]   rd_data_en,
  // Pins
  input  wire logic         media_change_input,
  input  wire logic [1:0]   reg_mode,
  // Sequencer side
  input  fdcrf_phase_t      core_phase,
  input  wire logic         core_dir,
  input  wire logic         core_in_valid,
  input  wire logic [7:0]   core_in_data,
  output logic              core_in_ready,
  output logic              core_out_valid,
  output logic      [7:0]   core_out_data,
  input  wire logic         core_out_ready,
  // Service requests and drive controls
  output logic              dma_request,
  output logic              irq_request,
  output logic      [1:0]   rate_select,
  output logic      [2:0]   write_shift_steps,
  output logic              low_power,
  output logic              rate_illegal,
  output logic              transfer_engine_on
);

  fdcrf_state_t s;
  fdcrf_state_t next_s;
  logic         soft_rst;
  logic         host_to_core;
  logic         fifo_live;
  logic         flush;
  logic [4:0]   cap;
  logic [3:0]   thr_eff;
  logic         port_wr;
  logic         port_rd;
  logic         push;
  logic         pop_host;
  logic         pop_core;
  logic [7:0]   push_data;
  logic         level_ok;
  logic         work_left;
  logic         density_flag;

  always_comb begin
    next_s = s;
    // Pins pass two flops; only the second stage is read below.
    next_s.media_s1 = media_change_input;
    next_s.media_s2 = s.media_s1;
    next_s.mode_s1  = reg_mode;
    next_s.mode_s2  = s.mode_s1;

    soft_rst = (wr_en && addr == ADDR_RATE_SEL && wr_data[RS_SW_RESET]) || !s.run;
    // RL19 sets direction per phase.
    host_to_core = (core_phase == PH_CMD) || (core_phase == PH_EXEC && !core_dir);
    // RL6 RL10 pick FIFO or bypass.
    fifo_live = (core_phase == PH_EXEC) && s.fifo_on && !(core_dir ? s.no_rd : s.no_wr);
    cap       = fifo_live ? CAP_FULL : CAP_BYPASS;
    thr_eff   = fifo_live ? s.level : 4'h0;
    flush     = soft_rst || (core_phase != s.prev_phase);
    next_s.prev_phase = core_phase;

    port_wr   = wr_en && addr == ADDR_DATA_PORT;
    port_rd   = rd_en && addr == ADDR_DATA_PORT;
    push      = host_to_core ? (port_wr && s.cnt < cap) : (core_in_valid && s.in_ready);
    push_data = host_to_core ? wr_data : core_in_data;
    pop_host  = !host_to_core && port_rd && s.cnt != 5'h00;
    pop_core  = host_to_core && s.cnt != 5'h00 && (!s.out_valid || core_out_ready);

    if (push) begin
      next_s.mem[s.wptr] = push_data;
      next_s.wptr        = s.wptr + 4'h1;
    end
    if (pop_host || pop_core) begin
      next_s.rptr = s.rptr + 4'h1;
    end
    next_s.cnt = s.cnt + {4'h0, push} - {4'h0, pop_host || pop_core};
    if (pop_core) begin
      next_s.out_valid = 1'b1;
      next_s.out_data  = s.mem[s.rptr];
    end else if (core_out_ready) begin
      next_s.out_valid = 1'b0;
    end
    // A phase change or soft reset empties the buffer so stale bytes never cross phases.
    if (flush) begin
      next_s.wptr      = 4'h0;
      next_s.rptr      = 4'h0;
      next_s.cnt       = 5'h00;
      next_s.out_valid = 1'b0;
    end
    next_s.in_ready = !host_to_core && next_s.cnt < cap;

    // Register writes.
    if (wr_en) begin
      case (addr)
        ADDR_RATE_SEL: begin
          next_s.low_power = wr_data[RS_LOW_POWER];
          next_s.precomp   = wr_data[RS_PRECOMP_LSB +: 3];
          // RL18 latest rate write.
          next_s.rate      = wr_data[1:0];
        end
        ADDR_RATE_CTL: begin
          next_s.skip_shift = wr_data[RC_SKIP_SHIFT];
          // RL18 latest rate write.
          next_s.rate       = wr_data[1:0];
        end
        ADDR_FIFO_CFG: begin
          next_s.fifo_on = wr_data[CFG_FIFO_ON];
          next_s.persist = wr_data[CFG_PERSIST];
          next_s.burst   = wr_data[CFG_BURST];
          // RL10 separate direction disables.
          next_s.no_rd   = wr_data[CFG_NO_RD];
          next_s.no_wr   = wr_data[CFG_NO_WR];
          next_s.fm      = wr_data[CFG_FM];
        end
        ADDR_FIFO_LEVEL: begin
          next_s.level = wr_data[3:0];
        end
        ADDR_OUT_CTL: begin
          next_s.engine_on = wr_data[OC_ENGINE_ON];
          next_s.run       = wr_data[OC_RUN];
        end
        default: begin
        end
      endcase
    end
    // Any data port access or main status read wakes the controller.
    if (port_wr || port_rd || (rd_en && addr == ADDR_MAIN_STATE)) begin
      next_s.low_power = 1'b0;
    end
    // RL3 RL7 RL14 soft reset spares rate and status.
    if (soft_rst) begin
      next_s.low_power = 1'b0;
      if (!s.persist) begin
        next_s.fifo_on = 1'b0;
      end
    end

    // Service requests follow the fill level against the threshold.
    level_ok  = core_dir ? (next_s.cnt > {1'b0, thr_eff})
                         : ((cap - next_s.cnt) > {1'b0, thr_eff});
    work_left = core_dir ? (next_s.cnt != 5'h00) : (next_s.cnt < cap);
    if (core_phase != PH_EXEC || flush) begin
      next_s.req = 1'b0;
      next_s.gap = 5'h00;
    end else if (s.burst) begin
      // RL8 holds request until done.
      next_s.req = (s.req && work_left) || level_ok;
      next_s.gap = 5'h00;
    end else begin
      // RL9 gap after each transfer.
      if (port_wr || port_rd) begin
        next_s.gap = GAP_CNT;
      end else if (s.gap != 5'h00) begin
        next_s.gap = s.gap - 5'h01;
      end
      next_s.req = level_ok && next_s.gap == 5'h00;
    end
    next_s.dma_req = next_s.req && next_s.engine_on;
    next_s.irq_req = next_s.req && !next_s.engine_on;

    // RL1 RL2 precompensation shift.
    if (next_s.precomp == PRECOMP_NONE) begin
      next_s.shift = SHIFT_ZERO;
    end else if (next_s.precomp == PRECOMP_DEFAULT) begin
      next_s.shift = (next_s.rate == RATE_1M) ? SHIFT_DEF_1M : SHIFT_DEF_LOW;
    end else begin
      next_s.shift = next_s.precomp;
    end
    // RL4 flags 1 Mb/s under FM.
    next_s.illegal = next_s.fm && next_s.rate == RATE_1M;

    // Read data stands only in the cycle after the strobe.
    density_flag      = !(s.rate == RATE_1M || s.rate == RATE_500);
    next_s.rd_data    = 8'h00;
    next_s.rd_data_en = 8'h00;
    if (rd_en) begin
      next_s.rd_data_en = 8'hff;
      case (addr)
        ADDR_IN_STATUS: begin
          // RL17 media bit is meaningless in power-down.
          // RL20 mode pins pick the layout.
          case (s.mode_s2)
            // RL15 second layout.
            MODE_SECOND: next_s.rd_data = {s.media_s2, DIR_ONES, s.rate, density_flag};
            // RL16 third layout.
            MODE_THIRD:  next_s.rd_data = {!s.media_s2, 3'h0, s.engine_on, s.skip_shift,
                                           s.rate};
            default: begin
              // RL13 legacy drives bit 7 only.
              next_s.rd_data    = {s.media_s2, 7'h00};
              next_s.rd_data_en = 8'h80;
            end
          endcase
        end
        ADDR_DATA_PORT:  next_s.rd_data = pop_host ? s.mem[s.rptr] : 8'h00;
        ADDR_MAIN_STATE: next_s.rd_data = {host_to_core ? (s.cnt < cap) : (s.cnt != 5'h00),
                                           !host_to_core,
                                           core_phase == PH_EXEC && !s.engine_on,
                                           core_phase != PH_CMD, 4'h0};
        ADDR_FIFO_CFG:   next_s.rd_data = {2'h0, s.fm, s.no_wr, s.no_rd, s.burst, s.persist,
                                           s.fifo_on};
        ADDR_FIFO_LEVEL: next_s.rd_data = {4'h0, s.level};
        ADDR_OUT_CTL:    next_s.rd_data = {4'h0, s.engine_on, s.run, 2'h0};
        default:         next_s.rd_data = 8'h00;
      endcase
    end
  end

  // RL3 RL11 hard reset defaults.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data            = s.rd_data;
  assign rd_data_en         = s.rd_data_en;
  assign core_in_ready      = s.in_ready;
  assign core_out_valid     = s.out_valid;
  assign core_out_data      = s.out_data;
  assign dma_request        = s.dma_req;
  assign irq_request        = s.irq_req;
  assign rate_select        = s.rate;
  assign write_shift_steps  = s.shift;
  assign low_power          = s.low_power;
  assign rate_illegal       = s.illegal;
  assign transfer_engine_on = s.engine_on;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  hw_rate_a: assert property (!$past(reset_n) |-> rate_select == RST_RATE) // RL3
    else $error("Rate not 250 kb/s after hard reset.");

  soft_rate_a: assert property ( // RL3
    (wr_en && addr == ADDR_OUT_CTL && !wr_data[OC_RUN]) |=> $stable(rate_select))
    else $error("Soft reset changed the rate.");

  rate_follow_a: assert property ( // RL18
    (wr_en && (addr == ADDR_RATE_CTL || addr == ADDR_RATE_SEL)) |=>
      rate_select == $past(wr_data[1:0]))
    else $error("Rate does not follow latest write.");

  shift_none_a: assert property ( // RL1
    (wr_en && addr == ADDR_RATE_SEL && wr_data[4:2] == PRECOMP_NONE) |=>
      write_shift_steps == SHIFT_ZERO)
    else $error("Code 111 did not give zero shift.");

  shift_default_a: assert property ( // RL2
    (wr_en && addr == ADDR_RATE_SEL && wr_data[4:2] == PRECOMP_DEFAULT) |=>
      write_shift_steps == ((rate_select == RATE_1M) ? SHIFT_DEF_1M : SHIFT_DEF_LOW))
    else $error("Default shift wrong for rate.");

  fifo_hw_a: assert property (!$past(reset_n) |-> !s.fifo_on && s.level == 4'h0) // RL11
    else $error("FIFO not in default state after reset.");

  lock_keep_a: assert property ( // RL7
    (soft_rst && s.fifo_on && !(wr_en && addr == ADDR_FIFO_CFG)) |=>
      s.fifo_on == $past(s.persist))
    else $error("FIFO enable wrong after soft reset.");

  bypass_a: assert property ((s.prev_phase != PH_EXEC) |-> s.cnt <= CAP_BYPASS) // RL6
    else $error("FIFO held bytes outside execution.");

  gap_low_a: assert property ( // RL9
    (core_phase == PH_EXEC && s.prev_phase == PH_EXEC && !s.burst && (port_wr || port_rd))
      |=> (!dma_request && !irq_request)[*8])
    else $error("Non-burst request not dropped.");

  burst_hold_a: assert property ( // RL8
    (s.req && s.burst && core_dir && core_phase == PH_EXEC && s.prev_phase == PH_EXEC &&
     s.cnt > 5'h01 && !soft_rst) |=> (dma_request || irq_request))
    else $error("Burst request dropped early.");

  at_mode_a: assert property ( // RL13
    (rd_en && addr == ADDR_IN_STATUS && s.mode_s2 == MODE_AT) |=>
      rd_data_en == 8'h80 && rd_data[7] == $past(s.media_s2))
    else $error("Legacy layout drives wrong bits.");

  second_mode_a: assert property ( // RL15
    (rd_en && addr == ADDR_IN_STATUS && s.mode_s2 == MODE_SECOND) |=>
      rd_data[6:0] == {DIR_ONES, $past(s.rate),
                       !($past(s.rate) == RATE_1M || $past(s.rate) == RATE_500)})
    else $error("Second layout wrong.");

  third_mode_a: assert property ( // RL16
    (rd_en && addr == ADDR_IN_STATUS && s.mode_s2 == MODE_THIRD) |=>
      rd_data == {!$past(s.media_s2), 3'h0, $past(s.engine_on), $past(s.skip_shift),
                  $past(s.rate)})
    else $error("Third layout wrong.");

  dir_flag_a: assert property ( // RL19
    (rd_en && addr == ADDR_MAIN_STATE && core_phase != PH_EXEC) |=>
      rd_data[6] == ($past(core_phase) == PH_RESULT))
    else $error("Direction flag wrong.");

  burst_fill_c: cover property (s.burst && s.req && s.cnt == CAP_FULL);
  gap_seen_c:   cover property (!s.burst && s.gap == GAP_CNT);
  fm_bad_c:     cover property (rate_illegal);
  third_rd_c:   cover property (rd_en && addr == ADDR_IN_STATUS && s.mode_s2 == MODE_THIRD);

endmodule : fdcrf_regs

/* File: bench/fdcrf_seq_model.sv */
// Command sequencer stand-in on the far side of the data port.
// Assumes the bench sets phase and direction and asks it to push bytes.
`timescale 1ns/1ps
module fdcrf_seq_model
  import fdcrf_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Bench control
  input  fdcrf_phase_t      set_phase,
  input  wire logic         set_dir,
  input  wire logic         push_go,
  input  wire logic [4:0]   push_len,
  input  wire logic [7:0]   push_base,
  input  wire logic         stall,
  output logic      [7:0]   got_byte,
  output logic      [7:0]   got_count,
  // Block side
  output fdcrf_phase_t      core_phase,
  output logic              core_dir,
  output logic              core_in_valid,
  output logic      [7:0]   core_in_data,
  input  wire logic         core_in_ready,
  input  wire logic         core_out_valid,
  input  wire logic [7:0]   core_out_data,
  output logic              core_out_ready
);
  logic [4:0] left;
  logic [7:0] cur;

  assign core_in_valid  = (left != 5'h00);
  // Idle data shows the inverse of the byte so a stale value never matches.
  assign core_in_data   = core_in_valid ? cur : ~cur;
  assign core_out_ready = ~stall;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      left       <= 5'h00;
      cur        <= 8'h00;
      got_byte   <= 8'h00;
      got_count  <= 8'h00;
      core_phase <= PH_CMD;
      core_dir   <= 1'b0;
    end else begin
      core_phase <= set_phase;
      core_dir   <= set_dir;
      if (push_go) begin
        left <= push_len;
        cur  <= push_base;
      end else if (core_in_valid && core_in_ready) begin
        left <= left - 5'h01;
        cur  <= cur + 8'h01;
      end
      if (core_out_valid && !stall) begin
        got_byte  <= core_out_data;
        got_count <= got_count + 8'h01;
      end
    end
  end
endmodule : fdcrf_seq_model

/* File: bench/fdc_rate_fifo_input_regs_bench.sv */
// Self-checking bench for the rate, data port and input status block.
// Assumes the sequencer stand-in drives the core side; the bench is the host.
`timescale 1ns/1ps
module fdc_rate_fifo_input_regs_bench;
  import fdcrf_pkg::*;
  logic         mclk, reset_n, wr_en, rd_en, media, push_go, stall, set_dir;
  logic         in_ready, in_valid, out_valid, out_ready, core_dir;
  logic         dma, irq, low_pw, illegal, engine;
  logic [1:0]   reg_mode, rate;
  logic [2:0]   addr, shift;
  logic [4:0]   push_len;
  logic [7:0]   wr_data, rd_data, rd_den, push_base, got_byte, got_count, in_data, out_data;
  fdcrf_phase_t set_phase, core_phase;
  int           num_errors, check_count;

  fdcrf_regs DUT (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_data_en(rd_den),
    .media_change_input(media), .reg_mode(reg_mode), .core_phase(core_phase),
    .core_dir(core_dir), .core_in_valid(in_valid), .core_in_data(in_data),
    .core_in_ready(in_ready), .core_out_valid(out_valid), .core_out_data(out_data),
    .core_out_ready(out_ready), .dma_request(dma), .irq_request(irq),
    .rate_select(rate), .write_shift_steps(shift), .low_power(low_pw),
    .rate_illegal(illegal), .transfer_engine_on(engine));

  fdcrf_seq_model partner (.mclk(mclk), .reset_n(reset_n), .set_phase(set_phase),
    .set_dir(set_dir), .push_go(push_go), .push_len(push_len), .push_base(push_base),
    .stall(stall), .got_byte(got_byte), .got_count(got_count), .core_phase(core_phase),
    .core_dir(core_dir), .core_in_valid(in_valid), .core_in_data(in_data),
    .core_in_ready(in_ready), .core_out_valid(out_valid), .core_out_data(out_data),
    .core_out_ready(out_ready));

  always #10 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] e);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    d = rd_data;
    e = rd_den;
  endtask : rd

  task automatic poll(input logic exp_dir);
    logic [7:0] s, e;
    int n;
    s = 8'h00;
    n = 0;
    while (s[7] !== 1'b1 && n < 50) begin
      rd(ADDR_MAIN_STATE, s, e);
      n++;
    end
    chk("request flag", 8'h01, {7'h00, s[7]});
    chk("direction flag", {7'h00, exp_dir}, {7'h00, s[6]});
  endtask : poll

  task automatic phase(input fdcrf_phase_t p, input logic d);
    @(posedge mclk);
    set_phase <= p;
    set_dir   <= d;
    repeat (3) @(posedge mclk);
  endtask : phase

  task automatic push(input logic [4:0] n, input logic [7:0] b);
    @(posedge mclk);
    push_go   <= 1'b1;
    push_len  <= n;
    push_base <= b;
    @(posedge mclk);
    push_go   <= 1'b0;
  endtask : push

  task automatic hard_reset();
    logic [7:0] d, e;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("rate", {6'h00, RST_RATE}, {6'h00, rate});
    chk("shift", {5'h00, SHIFT_DEF_LOW}, {5'h00, shift});
    chk("engine", 8'h00, {7'h00, engine});
    rd(ADDR_FIFO_CFG, d, e);
    chk("fifo on", 8'h00, {7'h00, d[CFG_FIFO_ON]});
    rd(ADDR_FIFO_LEVEL, d, e);
    chk("level", 8'h00, d);
    $display("test reset done");
  endtask : hard_reset

  task automatic t_precomp();
    for (int c = 1; c < 8; c++) begin
      wr(ADDR_RATE_SEL, {3'h0, 3'(c), RATE_1M});
      chk("shift", (c == 7) ? 8'h00 : 8'(c), {5'h00, shift});
    end
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_RATE_SEL, {6'h00, 2'(r)});
      chk("default shift", (r == 3) ? 8'h01 : 8'h03, {5'h00, shift});
      chk("rate", 8'(r), {6'h00, rate});
    end
    $display("test precomp done");
  endtask : t_precomp

  function automatic logic [7:0] dir_exp(input logic [1:0] m, input logic md,
                                         input logic [1:0] r);
    case (m)
      MODE_SECOND: return {md, DIR_ONES, r, (r == RATE_300 || r == RATE_250)};
      MODE_THIRD:  return {~md, 3'h0, 1'b1, 1'b1, r};
      default:     return {md, 7'h00};
    endcase
  endfunction : dir_exp

  task automatic t_modes();
    logic [7:0] d, e;
    wr(ADDR_OUT_CTL, 8'h0c);
    chk("engine", 8'h01, {7'h00, engine});
    rd(ADDR_RATE_CTL, d, e);
    chk("write-only data", 8'h00, d);
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk);
      reg_mode <= 2'(m);
      media    <= ~m[0];
      repeat (4) @(posedge mclk);
      for (int r = 0; r < 4; r++) begin
        wr(ADDR_RATE_CTL, {5'h01, 2'(r)});
        chk("rate", 8'(r), {6'h00, rate});
        rd(ADDR_IN_STATUS, d, e);
        chk("status", dir_exp(2'(m), ~m[0], 2'(r)), d);
        chk("status enable", (m == 0) ? 8'h80 : 8'hff, e);
      end
    end
    wr(ADDR_FIFO_CFG, 8'h20);
    chk("fm illegal", 8'h01, {7'h00, illegal});
    wr(ADDR_RATE_CTL, 8'h02);
    chk("fm legal", 8'h00, {7'h00, illegal});
    wr(ADDR_FIFO_CFG, 8'h00);
    $display("test modes done");
  endtask : t_modes

  task automatic t_cmd();
    logic [7:0] d, e, c0;
    c0 = got_count;
    stall <= 1'b1;
    poll(1'b0);
    wr(ADDR_DATA_PORT, 8'ha5);
    wr(ADDR_DATA_PORT, 8'h5a);
    wr(ADDR_DATA_PORT, 8'h3c);
    stall <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("command byte", 8'h5a, got_byte);
    chk("command count", c0 + 8'h02, got_count);
    phase(PH_RESULT, 1'b1);
    push(5'h02, 8'hc1);
    for (int i = 0; i < 2; i++) begin
      poll(1'b1);
      rd(ADDR_DATA_PORT, d, e);
      chk("result byte", 8'hc1 + 8'(i), d);
    end
    $display("test command done");
  endtask : t_cmd

  task automatic t_exec();
    logic [7:0] d, e;
    int n;
    wr(ADDR_FIFO_CFG, 8'h05);
    phase(PH_EXEC, 1'b1);
    push(5'h10, 8'h40);
    repeat (24) @(posedge mclk);
    chk("ready when full", 8'h00, {7'h00, in_ready});
    chk("irq with engine", 8'h00, {7'h00, irq});
    for (int i = 0; i < 16; i++) begin
      rd(ADDR_DATA_PORT, d, e);
      chk("fifo byte", 8'h40 + 8'(i), d);
      chk("burst request", (i < 15) ? 8'h01 : 8'h00, {7'h00, dma});
    end
    wr(ADDR_OUT_CTL, 8'h04);
    wr(ADDR_FIFO_CFG, 8'h01);
    push(5'h03, 8'h60);
    repeat (8) @(posedge mclk);
    chk("irq request", 8'h01, {7'h00, irq});
    rd(ADDR_DATA_PORT, d, e);
    n = 0;
    while (irq === 1'b0 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    chk("gap cycles", 8'(GAP_CYC), 8'(n));
    wr(ADDR_FIFO_CFG, 8'h09);
    rd(ADDR_DATA_PORT, d, e);
    rd(ADDR_DATA_PORT, d, e);
    chk("last byte", 8'h62, d);
    push(5'h03, 8'h70);
    repeat (6) @(posedge mclk);
    chk("read dir off", 8'h00, {7'h00, in_ready});
    rd(ADDR_DATA_PORT, d, e);
    chk("bypass byte", 8'h70, d);
    phase(PH_CMD, 1'b0);
    $display("test exec done");
  endtask : t_exec

  task automatic t_soft();
    logic [7:0] d, e, s0;
    wr(ADDR_RATE_SEL, {3'h2, 3'h5, RATE_300});
    chk("low power", 8'h01, {7'h00, low_pw});
    wr(ADDR_FIFO_CFG, 8'h03);
    wr(ADDR_FIFO_LEVEL, 8'h07);
    rd(ADDR_IN_STATUS, s0, e);
    wr(ADDR_OUT_CTL, 8'h00);
    wr(ADDR_OUT_CTL, 8'h04);
    chk("low power", 8'h00, {7'h00, low_pw});
    chk("rate", {6'h00, RATE_300}, {6'h00, rate});
    chk("shift", 8'h05, {5'h00, shift});
    rd(ADDR_FIFO_CFG, d, e);
    chk("locked fifo", 8'h01, {7'h00, d[CFG_FIFO_ON]});
    rd(ADDR_IN_STATUS, d, e);
    chk("status kept", s0, d);
    wr(ADDR_FIFO_CFG, 8'h01);
    wr(ADDR_RATE_SEL, 8'h95);
    rd(ADDR_FIFO_CFG, d, e);
    chk("unlocked fifo", 8'h00, {7'h00, d[CFG_FIFO_ON]});
    $display("test soft reset done");
  endtask : t_soft

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {wr_en, rd_en, media, push_go, stall, set_dir} = 6'h00;
    {reg_mode, addr, wr_data, push_len, push_base} = '0;
    set_phase = PH_CMD;
    num_errors = 0;
    check_count = 0;
    hard_reset();
    t_precomp();
    t_modes();
    t_cmd();
    t_exec();
    t_soft();
    hard_reset();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
endmodule : fdc_rate_fifo_input_regs_bench
